//--- abs_cmp.sv
// absolute difference comparator used by the three queue comparators
`timescale 1ns/100ps
module abs_cmp (
  // operands
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic [17:0] limit,
  // result
  output logic             hit
);
  logic [15:0] diff;
  assign diff = (a > b) ? (a - b) : (b - a);
  assign hit  = {2'b00, diff} > limit;
endmodule

//--- host_port_model.sv
// host side model: drives register writes and reads on the tracker's register port
`timescale 1ns/100ps
module host_port_model (
  // clock
  input  wire logic        sys_clk,
  // register port
  output logic [9:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // idle cycles after each access, so the host can be slow as well as prompt
  int gap = 0;
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic access(input logic [9:0] addr, input logic [15:0] wdata, input logic wr,
                        output logic [15:0] rdata);
    @(posedge sys_clk) #1;
    reg_addr = addr;
    reg_wdata = wdata;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // stale write data is inverted so nothing can lean on it
    reg_wdata = ~wdata;
    rdata = reg_rdata;
    repeat (gap) @(posedge sys_clk) #1;
  endtask
endmodule

//--- prox_pkg.sv
// package: register map, field positions and timing constants for the proximity tracker
package prox_pkg;
  localparam logic [9:0]  ADDR_SKIP_CFG   = 10'h002;
  localparam logic [9:0]  ADDR_LEVEL_CFG  = 10'h003;
  localparam logic [9:0]  ADDR_RECAL_CFG  = 10'h004;
  localparam logic [9:0]  ADDR_SPAN_BASE  = 10'h010;
  localparam logic [9:0]  ADDR_AMB_BASE   = 10'h020;
  localparam logic [9:0]  ADDR_STATUS     = 10'h030;
  localparam logic [15:0] SKIP_CFG_RST    = 16'h0000;
  localparam logic [15:0] LEVEL_CFG_RST   = 16'h0000;
  localparam logic [15:0] RECAL_CFG_RST   = 16'h0000;
  localparam int SKIP_LSB  = 0;
  localparam int SKIP_W    = 4;
  localparam int FPCNT_LSB = 4;
  localparam int LPCNT_LSB = 8;
  localparam int HOVER_LSB = 0;
  localparam int HOVER_W   = 8;
  localparam int RATE_LSB  = 8;
  localparam int RATE_W    = 6;
  localparam int UPD_LSB   = 14;
  localparam int FPREC_W   = 10;
  localparam int LPREC_LSB = 10;
  localparam int LEVEL_SHIFT = 4;
  localparam int FP_HOLD_MULT = 16;
  localparam int LP_HOLD_MULT = 4;
  localparam int STAGES    = 8;
  localparam int FQ_DEPTH  = 4;
  // fast queue period per stage slot at decimation 64, in microseconds
  localparam int FQ_BASE_US = 768;
  localparam int CLK_MHZ    = 100;
  localparam int FQ_BASE_CYC = FQ_BASE_US * CLK_MHZ;
endpackage

//--- proximity_ambient_tracker.sv
// proximity detection and ambient tracking, one stage slot per conversion result
`timescale 1ns/100ps
module proximity_ambient_tracker
  import prox_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // converter results, same clock
  input  wire logic        conv_valid,
  input  wire logic [2:0]  conv_stage,
  input  wire logic [15:0] conv_data,
  input  wire logic        seq_done,
  input  wire logic        low_power,
  // status
  output logic             proximity,
  output logic             int_out
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] skip_cfg_reg, level_cfg_reg, recal_cfg_reg;
  logic [15:0] span_reg [STAGES];
  logic [15:0] amb_reg  [STAGES];
  logic [15:0] fq_reg   [STAGES][FQ_DEPTH];
  logic [15:0] sq_reg   [STAGES];
  logic [3:0]  skip_reg [STAGES];
  logic [9:0]  hold_reg, recal_reg;
  logic [15:0] rdata_next;
  logic        prox_reg, int_reg;
  logic        hover_excess_seen;

  wire logic [3:0]  fast_queue_skip_count = skip_cfg_reg[SKIP_LSB +: SKIP_W];
  wire logic [3:0]  full_power_hold_count = skip_cfg_reg[FPCNT_LSB +: 4];
  wire logic [3:0]  low_power_hold_count  = skip_cfg_reg[LPCNT_LSB +: 4];
  wire logic [7:0]  hover_level      = level_cfg_reg[HOVER_LSB +: HOVER_W];
  wire logic [5:0]  approach_level   = level_cfg_reg[RATE_LSB +: RATE_W];
  wire logic [1:0]  ambient_update_level = level_cfg_reg[UPD_LSB +: 2];
  wire logic [9:0]  full_power_recal_timeout = recal_cfg_reg[FPREC_W-1:0];
  wire logic [5:0]  low_power_recal_timeout  = recal_cfg_reg[15:LPREC_LSB];

  // ****************************************
  // per-stage datapath
  // ****************************************
  wire logic [2:0]  st = conv_stage;
  wire logic [15:0] fast_sample_one   = fq_reg[st][1];
  wire logic [15:0] fast_sample_three = fq_reg[st][3];
  wire logic [15:0] slow_sample_zero  = conv_data;
  wire logic [15:0] slow_sample_one   = sq_reg[st];
  wire logic [15:0] ambient           = amb_reg[st];
  wire logic [17:0] fq_sum = 18'(fq_reg[st][0]) + 18'(fq_reg[st][1])
                           + 18'(fq_reg[st][2]) + 18'(fq_reg[st][3]);
  wire logic [15:0] fq_avg = fq_sum[17:2];
  // a counter left above a lowered skip count restarts at once instead of wrapping
  wire logic        fq_take = conv_valid && (skip_reg[st] >= fast_queue_skip_count);
  wire logic [17:0] rate_lim  = {8'h00, approach_level, 4'h0};
  wire logic [17:0] hover_lim = {6'h00, hover_level, 4'h0};
  wire logic [17:0] upd_lim   = {16'h0000, ambient_update_level};
  logic approach_hit, hover_hit, update_hit;

  abs_cmp u_approach (.a(fast_sample_one), .b(fast_sample_three), .limit(rate_lim),
                      .hit(approach_hit));
  abs_cmp u_hover (.a(fq_avg), .b(ambient), .limit(hover_lim),
                   .hit(hover_hit));
  abs_cmp u_update (.a(slow_sample_zero), .b(slow_sample_one), .limit(upd_lim),
                    .hit(update_hit));

  wire logic prox_now   = conv_valid && (approach_hit || hover_hit);
  wire logic cal_block  = prox_reg || prox_now || (hold_reg != 10'h000);
  wire logic slow_permit = update_hit && !prox_reg && !prox_now;
  wire logic amb_take   = conv_valid && slow_permit && !cal_block;
  wire logic [9:0] hold_load = low_power ? 10'(low_power_hold_count * LP_HOLD_MULT)
                                         : 10'(full_power_hold_count * FP_HOLD_MULT);
  wire logic [9:0] recal_lim = low_power ? {4'h0, low_power_recal_timeout}
                                         : full_power_recal_timeout;
  wire logic hover_excess = conv_valid && hover_hit && (fq_avg > ambient);
  wire logic force_recal  = (recal_lim != 10'h000) && (recal_reg >= recal_lim);
  // trips referenced from ambient with the programmed spans
  wire logic [16:0] upper_trip = 17'(ambient) + 17'(span_reg[st]);
  wire logic [15:0] lower_trip = (ambient > span_reg[st]) ? ambient - span_reg[st] : 16'h0000;
  wire logic touch = conv_valid && ((17'(conv_data) > upper_trip) || (conv_data < lower_trip));

  // ****************************************
  // register port decode
  // ****************************************
  wire logic sel_span = reg_addr[9:3] == ADDR_SPAN_BASE[9:3];
  wire logic sel_amb  = reg_addr[9:3] == ADDR_AMB_BASE[9:3];
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_addr == ADDR_SKIP_CFG) rdata_next = skip_cfg_reg;
    else if (reg_addr == ADDR_LEVEL_CFG) rdata_next = level_cfg_reg;
    else if (reg_addr == ADDR_RECAL_CFG) rdata_next = recal_cfg_reg;
    else if (sel_span) rdata_next = span_reg[reg_addr[2:0]];
    else if (sel_amb) rdata_next = amb_reg[reg_addr[2:0]];
    else if (reg_addr == ADDR_STATUS) rdata_next = {14'h0000, int_reg, prox_reg};
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      skip_cfg_reg  <= SKIP_CFG_RST;
      level_cfg_reg <= LEVEL_CFG_RST;
      recal_cfg_reg <= RECAL_CFG_RST;
      reg_rdata     <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == ADDR_SKIP_CFG) skip_cfg_reg <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_LEVEL_CFG) level_cfg_reg <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_RECAL_CFG) recal_cfg_reg <= reg_wdata;
      if (reg_rd) reg_rdata <= rdata_next;
    end
  end

  // ****************************************
  // per-stage memory
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < STAGES; i++) begin
        span_reg[i] <= 16'h0000;
        amb_reg[i]  <= 16'h0000;
        sq_reg[i]   <= 16'h0000;
        skip_reg[i] <= 4'h0;
        for (int j = 0; j < FQ_DEPTH; j++) fq_reg[i][j] <= 16'h0000;
      end
    end else begin
      if (reg_wr && sel_span) span_reg[reg_addr[2:0]] <= reg_wdata;
      if (reg_wr && sel_amb) amb_reg[reg_addr[2:0]] <= reg_wdata;
      if (conv_valid) begin
        skip_reg[st] <= fq_take ? 4'h0 : skip_reg[st] + 4'h1;
        if (fq_take) begin
          fq_reg[st][0] <= conv_data;
          for (int j = 1; j < FQ_DEPTH; j++) fq_reg[st][j] <= fq_reg[st][j-1];
        end
        if (amb_take) begin
          sq_reg[st]  <= conv_data;
          amb_reg[st] <= conv_data;
        end else if (force_recal) begin
          amb_reg[st] <= fq_avg;
        end
      end
    end
  end

  // ****************************************
  // proximity, hold-off and recalibration timers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prox_reg  <= 1'b0;
      int_reg   <= 1'b0;
      hold_reg  <= 10'h000;
      recal_reg <= 10'h000;
    end else begin
      if (conv_valid) prox_reg <= prox_now && !force_recal;
      if (conv_valid) int_reg <= touch;
      if (prox_now) hold_reg <= hold_load;
      else if (seq_done && hold_reg != 10'h000) hold_reg <= hold_reg - 10'h001;
      // cleared only by a conversion, so a timeout reached between results is not lost
      if (conv_valid && (force_recal || !hover_excess)) recal_reg <= 10'h000;
      else if (seq_done && hover_excess_seen) recal_reg <= recal_reg + 10'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) hover_excess_seen <= 1'b0;
    else if (conv_valid) hover_excess_seen <= hover_excess;
  end

  assign proximity = prox_reg;
  assign int_out   = int_reg;

  // ****************************************
  // checks
  // ****************************************
  a_prox_from_hits: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_valid && approach_hit && !force_recal |=> proximity)
    else $error("proximity not set after comparator hit");
  a_int_on_touch: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_valid |=> (int_out == $past(touch)))
    else $error("interrupt does not follow trip test");
  a_ambient_frozen: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_valid && prox_now && !force_recal && !(reg_wr && sel_amb)
      |=> amb_reg[$past(st)] == $past(ambient))
    else $error("ambient changed during proximity");
  a_hold_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
    prox_now |=> hold_reg == $past(hold_load))
    else $error("hold count not reloaded");
  a_skip_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    fq_take |=> skip_reg[$past(st)] == 4'h0)
    else $error("skip counter not cleared on entry");
  a_slow_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    amb_take |-> update_hit && !prox_reg)
    else $error("slow queue fed without permission");
  a_no_cal_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    hold_reg != 10'h000 |-> !amb_take)
    else $error("calibration during hold-off");
  a_recal_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    conv_valid && force_recal |=> recal_reg == 10'h000)
    else $error("recal timer not cleared");
  c_prox: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(proximity));
  c_touch: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(int_out));
  c_amb: cover property (@(posedge sys_clk) disable iff (!rstn) amb_take);
  c_recal: cover property (@(posedge sys_clk) disable iff (!rstn) force_recal);
endmodule

//--- proximity_ambient_tracker_bench.sv
// self-checking bench for the proximity and ambient tracker
`timescale 1ns/100ps
module proximity_ambient_tracker_bench
  import prox_pkg::*;
;
  logic        sys_clk;
  logic        rstn;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        conv_valid;
  logic [2:0]  conv_stage;
  logic [15:0] conv_data;
  logic        seq_done;
  logic        low_power;
  logic        proximity;
  logic        int_out;
  logic [15:0] rd;
  int          num_errors = 0;
  int          tests_run = 0;
  proximity_ambient_tracker u_proximity_ambient_tracker (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_stage(conv_stage),
    .conv_data(conv_data), .seq_done(seq_done), .low_power(low_power), .proximity(proximity),
    .int_out(int_out));
  host_port_model u_host_port_model (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ********************
  // helpers
  // ********************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    u_host_port_model.access(a, d, 1'b1, rd);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
    u_host_port_model.access(a, 16'h0000, 1'b0, rd);
    check(rd, exp);
  endtask
  // back to back results for one stage; outputs are read right after the last is taken
  task automatic feed(input logic [2:0] st, input logic [15:0] d, input int n);
    @(posedge sys_clk) #1;
    conv_valid = 1'b1;
    conv_stage = st;
    conv_data = d;
    repeat (n - 1) @(posedge sys_clk);
    @(posedge sys_clk) #1;
    conv_valid = 1'b0;
    conv_data = ~d;
  endtask
  // n back to back sequence ends
  task automatic pulse_seq(input int n);
    @(posedge sys_clk) #1;
    seq_done = 1'b1;
    repeat (n - 1) @(posedge sys_clk);
    @(posedge sys_clk) #1;
    seq_done = 1'b0;
  endtask
  task automatic do_reset;
    rstn = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic test_regs;
    rd_chk(ADDR_SKIP_CFG, SKIP_CFG_RST);
    rd_chk(ADDR_LEVEL_CFG, LEVEL_CFG_RST);
    wr(ADDR_LEVEL_CFG, 16'h04ff);
    rd_chk(ADDR_LEVEL_CFG, 16'h04ff);
    wr(10'h3ff, 16'hffff);
    rd_chk(10'h3ff, 16'h0000);
    $display("test regs done");
  endtask
  // long hold with no sequence ends keeps the ambient frozen for the next tests;
  // comparators look at the queue as it stood before the new result enters
  task automatic test_approach;
    wr(ADDR_SKIP_CFG, 16'h00f0);
    wr(ADDR_AMB_BASE, 16'h03e8);
    feed(3'd0, 16'h03e8, 4);
    for (int i = 0; i < 4; i++) begin
      feed(3'd0, 16'h0428, 1);
      check(16'(proximity), 16'h0000);
    end
    feed(3'd0, 16'h0469, 2);
    check(16'(proximity), 16'h0000);
    feed(3'd0, 16'h0469, 1);
    check(16'(proximity), 16'h0001);
    feed(3'd0, 16'h0469, 3);
    check(16'(proximity), 16'h0000);
    feed(3'd0, 16'h03e8, 3);
    check(16'(proximity), 16'h0001);
    $display("test approach done");
  endtask
  task automatic test_hover;
    wr(ADDR_AMB_BASE + 10'd1, 16'h03e8);
    wr(ADDR_LEVEL_CFG, 16'h3f02);
    feed(3'd1, 16'h0408, 8);
    check(16'(proximity), 16'h0000);
    feed(3'd1, 16'h040c, 4);
    check(16'(proximity), 16'h0001);
    $display("test hover done");
  endtask
  // every second result enters the queue, so one entry of the step is not yet enough
  task automatic test_skip;
    wr(ADDR_SKIP_CFG, 16'h00f1);
    wr(ADDR_AMB_BASE + 10'd2, 16'h03e8);
    feed(3'd2, 16'h03e8, 10);
    check(16'(proximity), 16'h0000);
    feed(3'd2, 16'h0438, 3);
    check(16'(proximity), 16'h0000);
    feed(3'd2, 16'h0438, 5);
    check(16'(proximity), 16'h0001);
    $display("test skip done");
  endtask
  task automatic test_touch;
    wr(ADDR_SKIP_CFG, 16'h00f0);
    wr(ADDR_SPAN_BASE + 10'd3, 16'h00c8);
    wr(ADDR_AMB_BASE + 10'd3, 16'h03e8);
    feed(3'd3, 16'h0514, 1);
    check(16'(int_out), 16'h0001);
    feed(3'd3, 16'h03e8, 1);
    check(16'(int_out), 16'h0000);
    feed(3'd3, 16'h02bc, 1);
    check(16'(int_out), 16'h0001);
    $display("test touch done");
  endtask
  // the first result of a jump still lands in the ambient; proximity follows from the queue
  task automatic test_ambient;
    do_reset();
    u_host_port_model.gap = 2;
    wr(ADDR_LEVEL_CFG, 16'h3fff);
    wr(ADDR_AMB_BASE + 10'd4, 16'h0200);
    feed(3'd4, 16'h0210, 4);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0210);
    feed(3'd4, 16'h0700, 3);
    check(16'(proximity), 16'h0001);
    feed(3'd4, 16'h0600, 1);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0700);
    $display("test ambient done");
  endtask
  // one full power hold unit is 16 sequence ends; the ambient waits for the last one
  task automatic test_holdoff;
    wr(ADDR_SKIP_CFG, 16'h0010);
    wr(ADDR_LEVEL_CFG, 16'h01ff);
    feed(3'd4, 16'h0600, 4);
    check(16'(proximity), 16'h0000);
    feed(3'd4, 16'h0600, 1);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0700);
    pulse_seq(15);
    feed(3'd4, 16'h0600, 1);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0700);
    pulse_seq(1);
    feed(3'd4, 16'h0600, 1);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0600);
    $display("test holdoff done");
  endtask
  // low power timeout of 2 sequences; the full power field holds 3 so the mode matters
  task automatic test_recal;
    low_power = 1'b1;
    wr(ADDR_RECAL_CFG, 16'h0803);
    wr(ADDR_LEVEL_CFG, 16'h0101);
    wr(ADDR_AMB_BASE + 10'd4, 16'h0500);
    feed(3'd4, 16'h0600, 1);
    check(16'(proximity), 16'h0001);
    pulse_seq(1);
    feed(3'd4, 16'h0600, 1);
    check(16'(proximity), 16'h0001);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0500);
    pulse_seq(1);
    feed(3'd4, 16'h0600, 1);
    check(16'(proximity), 16'h0000);
    rd_chk(ADDR_AMB_BASE + 10'd4, 16'h0600);
    low_power = 1'b0;
    $display("test recal done");
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    conv_valid = 1'b0;
    conv_stage = 3'd0;
    conv_data = 16'h0000;
    seq_done = 1'b0;
    low_power = 1'b0;
    do_reset();
    test_regs();
    test_approach();
    test_hover();
    test_skip();
    test_touch();
    test_ambient();
    test_holdoff();
    test_recal();
    end_of_test();
  end
endmodule
